// [rtl/card_pkg.sv]
// Purpose: constants and types of the memory card protocol block
// Assumes: clk_sys at 200 MHz; reader link far slower than clk_sys
// Notes:   byte widths, command codes and clock counts live here
// Operation
// - Erase sets ones; write ANDs data
// - Skip erase or write when not needed
// - Each erase or write step lasts 2.5 ms
// - Protection bits are permanent, lock low bytes
// - Security byte 0 counter, bytes 1-3 code
// - Locked from power-up until code matches
// - Spent counter refuses compares and modifications
// - Line changes only after link clock falls; code also moves it on reset edges and link disable
// - Reset fall starts answer from address zero
// - 33rd clock releases line after answer
// - Frame: start, 24 bits, clock, stop
// - Outgoing data; extra clock releases line
// - Processing holds line low until done
// - Reset rise with clock low aborts
// - Control, address, data bytes, LSB first
// - Seven control codes decoded
// - Data read streams to address 255
// - Protection read: 32 bits, then release
// - Update takes 255, 124 or 2 clocks
// - Protection write only when data matches
// - Security read hides code while locked
// - Locked security update only clears counter
// - Compare only inside verification sequence
// - Failures release line within eight clocks
package card_pkg;
	localparam int         CLK_PERIOD_NS  = 5;
	localparam int         STEP_TIME_NS   = 2500000;
	localparam int         STEP_CYCLES    =
		(STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] CMD_RD_DATA    = 8'h30;
	localparam logic [7:0] CMD_UPD_DATA   = 8'h38;
	localparam logic [7:0] CMD_RD_PROT    = 8'h34;
	localparam logic [7:0] CMD_WR_PROT    = 8'h3C;
	localparam logic [7:0] CMD_RD_SEC     = 8'h31;
	localparam logic [7:0] CMD_UPD_SEC    = 8'h39;
	localparam logic [7:0] CMD_CMP        = 8'h33;
	localparam logic [8:0] CLKS_TWO_STEPS = 9'h0FF;
	localparam logic [8:0] CLKS_ONE_STEP  = 9'h07C;
	localparam logic [8:0] CLKS_NO_STEP   = 9'h002;
	localparam logic [8:0] CLKS_FAIL      = 9'h004;
	localparam logic [8:0] FAIL_MAX_CLKS  = 9'h008;
	localparam logic [7:0] PROT_BYTES     = 8'h20;
	localparam logic [7:0] SEC_BYTES      = 8'h04;
	localparam logic [7:0] LAST_ADDR      = 8'hFF;
	localparam logic [7:0] SEC_LAST       = 8'h03;
	localparam logic [5:0] CMD_BITS       = 6'h18;
	localparam logic [5:0] CMD_CLKS       = 6'h19;
	localparam logic [2:0] EC_FULL        = 3'h7;
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_STATUS     = 8'h04;
	localparam int         CTRL_EN_BIT    = 0;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	typedef enum logic [2:0] {
		M_IDLE = 3'h0,
		M_CMD  = 3'h1,
		M_OUT  = 3'h2,
		M_PROC = 3'h3,
		M_HOLD = 3'h4
	} mode_t;
	typedef enum logic [1:0] {
		T_NONE = 2'h0,
		T_DATA = 2'h1,
		T_PROT = 2'h2,
		T_SEC  = 2'h3
	} target_t;
endpackage

// [rtl/card_mem_if.sv]
// Purpose: port between protocol logic and the data byte store
// Assumes: one access per cycle, read data one cycle late
// Notes:   write takes effect at the clock edge of we
`timescale 1ns/1ps
`default_nettype none
interface card_mem_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       we;
	modport host  (output addr, output wdata, output we, input rdata);
	modport store (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// [rtl/card_mem.sv]
// Purpose: 256 byte data store with registered read port
// Assumes: reset stands for power-up; cells come up erased
// Notes:   read sees the old byte in the cycle of a write
`timescale 1ns/1ps
`default_nettype none
module card_mem #(
	parameter int DEPTH = 256,
	parameter int AW    = 8
)(
	input wire logic   clk_sys,
	input wire logic   rst,
	card_mem_if.store  port
);
	typedef struct packed {
		logic [DEPTH-1:0][7:0] cells;
		logic [7:0]            rdata;
	} mem_state_t;

	mem_state_t st;
	mem_state_t nx;

	if (DEPTH != 2 ** AW || AW != 8) begin : g_chk
		$error("card_mem: DEPTH must be 2**AW with AW of 8");
	end

	always_comb begin
		nx = st;
		nx.rdata = st.cells[port.addr];
		if (port.we) begin
			nx.cells[port.addr] = port.wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '1;
		end else begin
			st <= nx;
		end
	end

	assign port.rdata = st.rdata;
endmodule
`default_nettype wire

// [rtl/card_protocol.sv]
// Purpose: serial protocol and command logic of a protected memory card
// Assumes: link pins are asynchronous; clk_sys far faster than link clock
// Notes:   AXI4-Lite slave holds link enable and a status word
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module card_protocol #(
	parameter int          STEP_CYC = card_pkg::STEP_CYCLES,
	parameter int          ADDR_W   = 4,
	// Arbitrary shipped code value
	parameter logic [23:0] REF_CODE = 24'hFFFFFF
)(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              cardClk,
	input  wire logic              cardRst,
	input  wire logic              ioIn,
	output logic                   ioOut,
	output logic                   ioOen,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready
);
	import card_pkg::*;

	localparam int TW = $clog2(2 * STEP_CYC + 1) + 1;

	if (STEP_CYC < 1 || ADDR_W < 3 || ADDR_W > 8) begin : g_chk
		$error("card_protocol: STEP_CYC or ADDR_W out of range");
	end

	typedef struct packed {
		logic [2:0]      clkSync;
		logic [2:0]      rstSync;
		logic [2:0]      ioSync;
		mode_t           mode;
		logic            atr;
		logic [5:0]      bitCnt;
		logic [23:0]     shift;
		target_t         src;
		target_t         tgt;
		logic [7:0]      outAddr;
		logic            outLast;
		logic [7:0]      pAddr;
		logic [7:0]      pData;
		logic            fail;
		logic            started;
		logic [8:0]      need;
		logic [8:0]      falls;
		logic [1:0]      steps;
		logic [TW-1:0]   timer;
		logic [31:0]     protBits;
		logic [2:0][7:0] secRef;
		logic [2:0]      ec;
		logic            unlocked;
		logic [1:0]      vstage;
		logic            ioOen;
		logic            ioOut;
		logic            linkEn;
		logic            awHave;
		logic            wHave;
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic            arready;
		logic            rvalid;
		logic [ADDR_W-1:0] awAddr;
		logic [31:0]     wData;
		logic            wLane0;
		logic [31:0]     rdata;
		logic [1:0]      bresp;
		logic [1:0]      rresp;
	} state_t;

	state_t        st;
	state_t        nx;
	card_mem_if    mem ();
	logic          clkS;
	logic          clkRise;
	logic          clkFall;
	logic          rstRise;
	logic          rstFall;
	logic          ioS;
	logic          startCond;
	logic          stopCond;
	logic [7:0]    cCtl;
	logic [7:0]    cAd;
	logic [7:0]    cDt;
	logic [9:0]    chgMem;
	logic [9:0]    chgSec;
	logic [9:0]    uChg;
	logic          doUpd;
	target_t       uTgt;
	logic [7:0]    outByte;
	logic [7:0]    endAddr;
	logic [TW-1:0] stepTarget;
	logic [31:0]   statusWord;

	// Returns erase needed, write needed, resulting byte
	function automatic logic [9:0] chg(input logic [7:0] oldB,
		input logic [7:0] newB);
		logic       er;
		logic [7:0] base;
		er = |(~oldB & newB);
		base = er ? 8'hFF : oldB;
		return {er, |(base & ~newB), base & newB};
	endfunction

	// Counter byte carries three bits; code bytes read low while locked
	function automatic logic [7:0] secByte(input logic [1:0] a,
		input logic [2:0] ec, input logic ul,
		input logic [2:0][7:0] code);
		if (a == 2'h0) begin
			return {5'h00, ec};
		end
		return ul ? code[2'(a - 2'h1)] : 8'h00;
	endfunction

	function automatic logic inProt(input logic [7:0] a);
		return a < PROT_BYTES;
	endfunction

	function automatic logic [8:0] clocksFor(input logic [1:0] n);
		case (n)
			2'h2:    return CLKS_TWO_STEPS;
			2'h1:    return CLKS_ONE_STEP;
			default: return CLKS_NO_STEP;
		endcase
	endfunction

	function automatic logic regMapped(input logic [ADDR_W-1:0] a);
		return a == ADDR_W'(REG_CTRL) || a == ADDR_W'(REG_STATUS);
	endfunction

	card_mem #(
		.DEPTH (256),
		.AW    (8)
	) u_mem (
		.clk_sys (clk_sys),
		.rst     (rst),
		.port    (mem.store)
	);

	assign clkS = st.clkSync[1];
	assign clkRise = st.clkSync[1] & ~st.clkSync[2];
	assign clkFall = ~st.clkSync[1] & st.clkSync[2];
	assign rstRise = st.rstSync[1] & ~st.rstSync[2];
	assign rstFall = ~st.rstSync[1] & st.rstSync[2];
	assign ioS = st.ioSync[1];
	assign startCond = ~ioS & st.ioSync[2] & clkS;
	assign stopCond = ioS & ~st.ioSync[2] & clkS;
	assign cCtl = st.shift[7:0];
	assign cAd = st.shift[15:8];
	assign cDt = st.shift[23:16];
	assign chgMem = chg(mem.rdata, cDt);
	assign chgSec = chg(secByte(cAd[1:0], st.ec, st.unlocked, st.secRef),
		cDt);
	always_comb begin
		case (st.src)
			T_PROT:  outByte = st.protBits[st.outAddr[1:0] * 8 +: 8];
			T_SEC:   outByte = secByte(st.outAddr[1:0], st.ec,
				st.unlocked, st.secRef);
			default: outByte = mem.rdata;
		endcase
	end
	assign endAddr = (st.src == T_DATA && !st.atr) ? LAST_ADDR : SEC_LAST;
	assign stepTarget = TW'(st.steps * STEP_CYC);
	assign statusWord = 32'({st.mode, ~st.ioOen, st.vstage, st.ec,
		st.unlocked});
	assign mem.addr = (st.mode == M_PROC) ? st.pAddr :
		(st.mode == M_IDLE || st.mode == M_CMD) ? cAd : st.outAddr;
	assign mem.wdata = st.pData;

	always_comb begin
		nx = st;
		mem.we = 1'b0;
		doUpd = 1'b0;
		uTgt = T_NONE;
		uChg = chgMem;
		// Two flip-flops before any logic looks at the pins
		nx.clkSync = {st.clkSync[1:0], cardClk};
		nx.rstSync = {st.rstSync[1:0], cardRst};
		nx.ioSync = {st.ioSync[1:0], ioIn};
		if (st.mode == M_PROC && st.started && st.timer < stepTarget) begin
			nx.timer = TW'(st.timer + 1'b1);
		end
		if (!st.linkEn) begin
			nx.mode = M_IDLE;
			nx.ioOen = 1'b1;
		end else if (rstRise) begin
			nx.mode = M_HOLD;
			nx.ioOen = 1'b1;
			nx.atr = 1'b0;
			nx.outAddr = 8'h00;
		end else begin
			case (st.mode)
				M_HOLD: begin
					if (rstFall) begin
						nx.mode = M_OUT;
						nx.atr = 1'b1;
						nx.src = T_DATA;
						nx.bitCnt = 6'h01;
						nx.outLast = 1'b0;
						nx.ioOen = mem.rdata[0];
					end
				end
				M_IDLE: begin
					if (startCond) begin
						nx.mode = M_CMD;
						nx.bitCnt = 6'h00;
					end
				end
				M_CMD: begin
					if (startCond) begin
						nx.bitCnt = 6'h00;
					end else if (clkRise) begin
						if (st.bitCnt < CMD_BITS) begin
							nx.shift = {ioS, st.shift[23:1]};
						end
						if (st.bitCnt != 6'h3F) begin
							nx.bitCnt = 6'(st.bitCnt + 1'b1);
						end
					end else if (stopCond) begin
						nx.mode = M_IDLE;
						if (st.bitCnt == CMD_CLKS) begin
							nx.mode = M_PROC;
							nx.fail = 1'b1;
							nx.need = CLKS_FAIL;
							nx.steps = 2'h0;
							nx.tgt = T_NONE;
							nx.started = 1'b0;
							nx.falls = 9'h000;
							nx.timer = '0;
							nx.bitCnt = 6'h00;
							nx.outLast = 1'b0;
							nx.outAddr = 8'h00;
							nx.pAddr = cAd;
							nx.vstage = 2'h0;
							case (cCtl)
								CMD_RD_DATA: begin
									nx.mode = M_OUT;
									nx.src = T_DATA;
									nx.outAddr = cAd;
								end
								CMD_RD_PROT: begin
									nx.mode = M_OUT;
									nx.src = T_PROT;
								end
								CMD_RD_SEC: begin
									nx.mode = M_OUT;
									nx.src = T_SEC;
								end
								CMD_UPD_DATA: begin
									doUpd = st.unlocked &&
										!(inProt(cAd) && st.protBits[cAd[4:0]]);
									uTgt = T_DATA;
								end
								CMD_WR_PROT: begin
									if (st.unlocked && inProt(cAd) &&
										!st.protBits[cAd[4:0]] &&
										mem.rdata == cDt) begin
										nx.fail = 1'b0;
										nx.tgt = T_PROT;
										nx.steps = 2'h1;
										nx.need = clocksFor(2'h1);
									end
								end
								CMD_UPD_SEC: begin
									uChg = chgSec;
									uTgt = T_SEC;
									if (cAd < SEC_BYTES) begin
										doUpd = st.unlocked;
										if (!st.unlocked && cAd == 8'h00 &&
											!chgSec[9] && chgSec[8]) begin
											doUpd = 1'b1;
											nx.vstage = 2'h1;
										end
									end
								end
								CMD_CMP: begin
									if (st.vstage != 2'h0 &&
										cAd == {6'h00, st.vstage} &&
										st.secRef[2'(st.vstage - 2'h1)] == cDt)
										begin
										nx.fail = 1'b0;
										nx.need = CLKS_NO_STEP;
										nx.vstage = 2'(st.vstage + 2'h1);
										if (st.vstage == 2'h3) begin
											nx.unlocked = 1'b1;
											nx.vstage = 2'h0;
										end
									end
								end
								default: begin
									nx.fail = 1'b1;
								end
							endcase
							if (doUpd) begin
								nx.fail = 1'b0;
								nx.tgt = uTgt;
								nx.pData = uChg[7:0];
								nx.steps = {1'b0, uChg[9]} + {1'b0, uChg[8]};
								nx.need = clocksFor(nx.steps);
							end
						end
					end
				end
				M_OUT: begin
					if (clkFall) begin
						if (st.outLast) begin
							nx.mode = M_IDLE;
							nx.ioOen = 1'b1;
							nx.atr = 1'b0;
						end else begin
							nx.ioOen = outByte[st.bitCnt[2:0]];
							nx.bitCnt = 6'(st.bitCnt + 1'b1);
							if (st.bitCnt[2:0] == 3'h7) begin
								if (st.outAddr == endAddr) begin
									nx.outLast = 1'b1;
								end else begin
									nx.outAddr = 8'(st.outAddr + 1'b1);
								end
							end
						end
					end
				end
				M_PROC: begin
					if (clkFall) begin
						nx.falls = 9'(st.falls + 1'b1);
						if (!st.started) begin
							nx.started = 1'b1;
							nx.ioOen = 1'b0;
						end else if (9'(st.falls + 1'b1) >= st.need &&
							st.timer >= stepTarget) begin
							nx.mode = M_IDLE;
							nx.ioOen = 1'b1;
							case (st.tgt)
								T_DATA: mem.we = 1'b1;
								T_PROT: nx.protBits[st.pAddr[4:0]] = 1'b1;
								T_SEC: begin
									if (st.pAddr[1:0] == 2'h0) begin
										nx.ec = st.pData[2:0];
									end else begin
										nx.secRef[2'(st.pAddr[1:0] - 2'h1)] =
											st.pData;
									end
								end
								default: begin
									nx.tgt = T_NONE;
								end
							endcase
						end
					end
				end
				default: begin
					nx.mode = M_IDLE;
				end
			endcase
		end
		// Register bus: one write and one read under way at a time
		if (st.awready && awvalid) begin
			nx.awHave = 1'b1;
			nx.awAddr = awaddr;
		end
		if (st.wready && wvalid) begin
			nx.wHave = 1'b1;
			nx.wData = wdata;
			nx.wLane0 = wstrb[0];
		end
		if (st.bvalid && bready) begin
			nx.bvalid = 1'b0;
		end
		if (st.awHave && st.wHave && !st.bvalid) begin
			nx.awHave = 1'b0;
			nx.wHave = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = regMapped(st.awAddr) ? RESP_OKAY : RESP_SLVERR;
			if (st.awAddr == ADDR_W'(REG_CTRL) && st.wLane0) begin
				nx.linkEn = st.wData[CTRL_EN_BIT];
			end
		end
		if (st.rvalid && rready) begin
			nx.rvalid = 1'b0;
		end
		if (st.arready && arvalid) begin
			nx.rvalid = 1'b1;
			nx.rresp = regMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			nx.rdata = (araddr == ADDR_W'(REG_CTRL)) ? 32'(st.linkEn) :
				(araddr == ADDR_W'(REG_STATUS)) ? statusWord : 32'h0;
		end
		nx.awready = !nx.awHave;
		nx.wready = !nx.wHave;
		nx.arready = !nx.rvalid;
		nx.ioOut = 1'b0;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
			st.linkEn <= 1'b1;
			st.ioOen <= 1'b1;
			st.ec <= EC_FULL;
			st.secRef <= REF_CODE;
		end else begin
			st <= nx;
		end
	end

	assign ioOut = st.ioOut;
	assign ioOen = st.ioOen;
	assign awready = st.awready;
	assign wready = st.wready;
	assign bresp = st.bresp;
	assign bvalid = st.bvalid;
	assign arready = st.arready;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign rvalid = st.rvalid;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_line_on_fall: assert property ($changed(st.ioOen) |->
		$past(clkFall) || $past(rstRise) || $past(rstFall) ||
		!$past(st.linkEn))
		else $error("data line changed without a link clock fall");
	a_break_release: assert property (rstRise && st.linkEn |=>
		st.ioOen && st.mode == M_HOLD)
		else $error("break did not release the line");
	a_atr_start: assert property (st.mode == M_HOLD && rstFall &&
		st.linkEn && !rstRise |=> st.mode == M_OUT && st.atr &&
		st.outAddr == 8'h00 && st.bitCnt == 6'h01)
		else $error("answer to reset did not start at address zero");
	a_atr_release: assert property (st.mode == M_OUT && st.atr &&
		st.outLast && clkFall && st.linkEn && !rstRise |=>
		st.ioOen && st.mode == M_IDLE)
		else $error("answer to reset did not release the line");
	a_step_time: assert property (st.mode == M_PROC &&
		nx.mode == M_IDLE && st.linkEn |-> st.timer >= stepTarget)
		else $error("processing ended before the step time");
	a_prot_sticky: assert property (
		($past(st.protBits) & ~st.protBits) == 32'h0)
		else $error("a protection bit was erased");
	a_locked_write: assert property (mem.we |-> st.unlocked)
		else $error("data written while locked");
	a_counter_spent: assert property (!st.unlocked &&
		st.ec == 3'h0 && st.vstage == 2'h0 |=> !st.unlocked)
		else $error("unlocked with a spent attempt counter");
	a_step_clocks: assert property (st.mode == M_PROC &&
		!st.fail && st.steps == 2'h2 |-> st.need == CLKS_TWO_STEPS)
		else $error("two step update with wrong clock count");
	a_fail_release: assert property (st.mode == M_PROC &&
		st.fail |-> st.need <= FAIL_MAX_CLKS && st.tgt == T_NONE)
		else $error("failure holds the line too long");
	a_single_step: assert property (mem.we &&
		st.steps != 2'h2 |-> (mem.wdata & ~mem.rdata) == 8'h00 ||
		(mem.rdata & ~mem.wdata) == 8'h00)
		else $error("single step changed bits both ways");
endmodule
`default_nettype wire

// [tb/card_host.sv]
// Purpose: card reader model driving link clock, reset and data line
// Assumes: 32 clk_sys cycles per link clock, line pulled up
// Notes:   link clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module card_host (
	input  wire logic clk_sys,
	input  wire logic ioOut,
	input  wire logic ioOen,
	output logic      cardClk,
	output logic      cardRst,
	output logic      ioIn
);
	logic hostDrv;
	// Open drain: low if either side pulls
	assign ioIn = hostDrv & (ioOen | ioOut);
	initial begin
		cardClk = 1'b0;
		cardRst = 1'b0;
		hostDrv = 1'b1;
	end
	task automatic q();
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic pulse();
		cardClk <= 1'b1;
		q();
		q();
		cardClk <= 1'b0;
		q();
		q();
	endtask
	task automatic cmd(input logic [23:0] w);
		cardClk <= 1'b1;
		q();
		hostDrv <= 1'b0;
		q();
		cardClk <= 1'b0;
		q();
		for (int i = 0; i < 25; i++) begin
			hostDrv <= (i < 24) ? w[i] : 1'b0;
			q();
			cardClk <= 1'b1;
			q();
			if (i == 24)
				hostDrv <= 1'b1;
			q();
			cardClk <= 1'b0;
			q();
		end
	endtask
	// bits, then one clock to release
	task automatic rd(input int s, input int n, output logic [31:0] v);
		v = '0;
		v[0] = ioIn;
		for (int i = s; i < n; i++) begin
			pulse();
			v[i] = ioIn;
		end
		pulse();
	endtask
	// clock on until the line is let go
	task automatic proc(output int n);
		n = 0;
		do begin
			pulse();
			n++;
		end while (ioIn === 1'b0 && n < 400);
	endtask
	task automatic brk();
		cardRst <= 1'b1;
		q();
		q();
	endtask
	task automatic atr(output logic [31:0] v);
		brk();
		cardClk <= 1'b1;
		q();
		q();
		cardClk <= 1'b0;
		q();
		cardRst <= 1'b0;
		q();
		q();
		rd(1, 32, v);
	endtask
endmodule
`default_nettype wire

// [tb/secure_memory_card_protocol_tb_top.sv]
// Purpose: register and link scenarios for the card protocol block
// Assumes: STEP_CYC shortened so fall counts govern timing
// Notes:   reference code left at its default of all ones
`timescale 1ns/1ps
`default_nettype none
module secure_memory_card_protocol_tb_top;
	import card_pkg::*;
	logic        clk_sys, rst, cardClk, cardRst, ioIn, ioOut, ioOen;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, v;
	logic [1:0]  bresp, rresp, r;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          errors, cmpCount, n;
	card_protocol #(.STEP_CYC(20), .ADDR_W(4)) card_protocol_i (.clk_sys,
		.rst, .cardClk, .cardRst, .ioIn, .ioOut, .ioOen, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	card_host card_host_i (.clk_sys, .ioOut, .ioOen, .cardClk, .cardRst,
		.ioIn);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic final_report();
		if (errors == 0 && cmpCount > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmpCount++;
		if (g !== e) begin
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
			errors++;
		end
	endtask
	task automatic tmo(input int k);
		if (k >= 100) begin
			errors++;
			final_report();
		end
	endtask
	task automatic axiRd(input logic [3:0] a);
		int k;
		k = 0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (arready !== 1'b1 && k < 100);
		arvalid <= 1'b0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (rvalid !== 1'b1 && k < 100);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
		tmo(k);
	endtask
	task automatic axiWr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int k;
		k = 0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && k < 100);
		r = bresp;
		bready <= 1'b0;
		tmo(k);
	endtask
	// Command word is data, address, control
	task automatic lnk(input logic [23:0] w, input int e);
		card_host_i.cmd(w);
		chk(ioIn, 1'b0);
		card_host_i.proc(n);
		if (n >= 400)
			tmo(100);
		// Frame's closing fall is the first processing fall
		chk(n + 1, e);
	endtask
	initial begin
		{rst, awaddr, araddr, wstrb, wdata} = {1'b1, 8'h00, 4'hF, 32'h0};
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		errors = 0;
		cmpCount = 0;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		axiRd(4'h0);
		chk(v, 32'h1);
		chk(r, RESP_OKAY);
		axiRd(4'h4);
		chk(v, 32'hE);
		axiRd(4'h8);
		chk({v[29:0], r}, {30'h0, RESP_SLVERR});
		axiWr(4'h0, 32'h0, 4'h0);
		chk(r, RESP_OKAY);
		axiWr(4'h8, 32'h0, 4'hF);
		chk(r, RESP_SLVERR);
		axiWr(4'h4, 32'h0, 4'hF);
		chk(r, RESP_OKAY);
		axiRd(4'h0);
		chk(v, 32'h1);
		axiWr(4'h0, 32'h0, 4'hF);
		axiRd(4'h0);
		chk(v, 32'h0);
		chk(ioOut, 1'b0);
		axiWr(4'h0, 32'h1, 4'hF);
		card_host_i.atr(v);
		chk(v, 32'hFFFFFFFF);
		chk(ioOen, 1'b1);
		lnk(24'h5AFC38, 4);
		lnk(24'h000000, 4);
		card_host_i.cmd(24'h000031);
		card_host_i.rd(1, 32, v);
		chk(v, 32'h7);
		lnk(24'h060039, 124);
		lnk(24'hFF0133, 2);
		lnk(24'hFF0233, 2);
		lnk(24'hFF0333, 2);
		axiRd(4'h4);
		chk(v & 32'hF, 32'hD);
		card_host_i.cmd(24'h000031);
		card_host_i.rd(1, 32, v);
		chk(v, 32'hFFFFFF06);
		lnk(24'hFF0039, 124);
		axiRd(4'h4);
		chk(v & 32'hF, 32'hF);
		lnk(24'h5AFC38, 124);
		lnk(24'hA5FC38, 255);
		card_host_i.cmd(24'h00FD38);
		repeat (5) card_host_i.pulse();
		card_host_i.brk();
		chk(ioOen, 1'b1);
		card_host_i.atr(v);
		chk(v, 32'hFFFFFFFF);
		card_host_i.cmd(24'h00FC30);
		card_host_i.rd(1, 32, v);
		chk(v, 32'hFFFFFFA5);
		chk(ioOen, 1'b1);
		lnk(24'hFF013C, 124);
		card_host_i.cmd(24'h000034);
		card_host_i.rd(1, 32, v);
		chk(v, 32'h2);
		lnk(24'h000138, 4);
		lnk(24'hFF013C, 4);
		final_report();
	end
endmodule
`default_nettype wire
